// ==== src/acr_adc_ctrl.sv ====
// control and serial readout logic of a 10-bit successive-approximation converter
//
// Summary of operation
// - every rising edge of the start pin enables the serial output port
// - a read may start any time after the start pin rises
// - a read during conversion shifts out the previous result
// - new result waits until a running read has finished
// - conversion lasts 2.3 us from the falling start edge
// - start pin still low at conversion end powers the core down
// - powered-down core begins a 1.5 us power-up on a rising start edge
// - early falling edge waits out power-up, then converts; late edge converts at once
// - in auto power-down, result is stored on the same edge as the core powers down
// - serial port keeps working while the core is powered down
// - rising start edge clears the bit counter counting shift clocks
// - after ten bits further shift clock edges are ignored
// - each rising shift clock edge drives the next result bit
// - data output released on the falling edge of the tenth shift clock
// - nothing is shifted out before a rising start edge is seen
// - readout works with continuous or burst shift clock
// - falling start edge ends tracking, enters hold and starts conversion
// - result is straight binary, one code step per reference over 1024
// - after power-on the core sits powered down awaiting a rising edge
`timescale 1ns/1ns

module acr_adc_ctrl
  import acr_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   arst_n,
  input  wire logic                   conv_start_n,
  input  wire logic                   shift_clock,
  input  wire logic [RESULT_BITS-1:0] analog_code,
  output logic                        serial_data_out,
  output logic                        serial_data_oe,
  output logic                        core_powered,
  output logic                        core_hold,
  output logic                        read_active,
  output logic                        result_deferred,
  output logic [RESULT_BITS-1:0]      result_word
);

  // interval timer terminal test, shared by power-up and conversion
  function automatic logic tmr_hit(
    input logic [TMR_W-1:0] count,
    input logic [TMR_W-1:0] last
  );
    tmr_hit = (count == last);
  endfunction : tmr_hit

  // picks one result bit, counting from the most significant end
  function automatic logic pick_bit(
    input logic [RESULT_BITS-1:0] word,
    input logic [BIT_CNT_W-1:0]   sent
  );
    pick_bit = word[MSB_IDX - sent];
  endfunction : pick_bit

  logic                   cs_meta;
  logic                   cs_sync;
  logic                   cs_prev;
  logic                   sck_meta;
  logic                   sck_sync;
  logic                   sck_prev;
  logic                   cs_rise;
  logic                   cs_fall;
  logic                   sck_rise;
  logic                   sck_fall;
  acr_state_t             state;
  acr_state_t             next_state;
  logic [TMR_W-1:0]       tmr;
  logic                   fall_pend;
  logic                   conv_end;
  logic [RESULT_BITS-1:0] held_code;
  logic [RESULT_BITS-1:0] conv_word;
  logic                   result_pend;
  logic [RESULT_BITS-1:0] out_word;
  logic                   port_armed;
  logic [BIT_CNT_W-1:0]   bit_cnt;
  logic                   reading;
  logic                   load_out;

  // start pin synchroniser; the first stage feeds only the second
  // an edge reaches the control logic three sys_clk cycles after the pin moves,
  // so a start pulse is only seen if at least one rising sys_clk edge samples it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_meta <= CS_RST;
      cs_sync <= CS_RST;
      cs_prev <= CS_RST;
    end else begin
      cs_meta <= conv_start_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  // shift clock synchroniser; sampled, so its period must span several sys_clk
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_meta <= SCK_RST;
      sck_sync <= SCK_RST;
      sck_prev <= SCK_RST;
    end else begin
      sck_meta <= shift_clock;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
    end
  end

  // edge detection on the synchronised levels, so bursts need no free-running clock
  assign cs_rise  = cs_sync & ~cs_prev;
  assign cs_fall  = ~cs_sync & cs_prev;
  assign sck_rise = sck_sync & ~sck_prev;
  assign sck_fall = ~sck_sync & sck_prev;

  // conversion finishes on the last cycle of the conversion interval
  assign conv_end = (state == ST_CONV) && tmr_hit(tmr, CONV_LAST);

  // core power and conversion sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (cs_rise) begin
          next_state = ST_PWRUP;
        end
      end
      ST_PWRUP: begin
        if (tmr_hit(tmr, PWRUP_LAST)) begin
          if (fall_pend || cs_fall) begin
            next_state = ST_CONV;
          end else begin
            next_state = ST_READY;
          end
        end
      end
      ST_READY: begin
        if (cs_fall) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_end) begin
          // pin level at the end decides the mode; it is the synchronised
          // level, so the host must settle the pin a few cycles ahead of the end
          if (cs_sync) begin
            next_state = ST_READY;
          end else begin
            next_state = ST_OFF;
          end
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // state register; reset stands for power-on, which leaves the core off
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // interval timer on sys_clk only, restarted on every state change
  // one timer serves both intervals; seven bits hold the longer one with room
  // a shift clock never touches it, so reads cannot stretch a conversion
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr <= TMR_RST;
    end else if (next_state != state) begin
      tmr <= TMR_RST;
    end else if ((state == ST_PWRUP) || (state == ST_CONV)) begin
      tmr <= TMR_W'(tmr + 1'b1);
    end else begin
      tmr <= TMR_RST;
    end
  end

  // remembers a falling edge that came before power-up ran out
  // a fall on the very last power-up cycle is taken by the state logic itself
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fall_pend <= 1'b0;
    end else if (state != ST_PWRUP) begin
      fall_pend <= 1'b0;
    end else if (cs_fall) begin
      fall_pend <= 1'b1;
    end
  end

  // hold: the input is captured as the conversion begins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      held_code <= RESULT_RST;
    end else if ((next_state == ST_CONV) && (state != ST_CONV)) begin
      held_code <= analog_code;
    end
  end

  // finished result, coded straight binary as the core delivers it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_word <= RESULT_RST;
    end else if (conv_end) begin
      conv_word <= held_code;
    end
  end

  // a read is running from the first rising shift clock until the tenth fall;
  // the rising edge itself counts, otherwise a load in that very cycle would
  // send bit 9 of the old word and bits 8..0 of the new one
  assign reading  = port_armed && ((bit_cnt != BIT_CNT_RST) || sck_rise);
  assign load_out = result_pend && !reading;

  // deferred load flag; a new completion wins over the clearing load
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_pend <= 1'b0;
    end else if (conv_end) begin
      result_pend <= 1'b1;
    end else if (load_out) begin
      result_pend <= 1'b0;
    end
  end

  // output word changes only between reads, so a read never mixes results
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_word <= RESULT_RST;
    end else if (load_out) begin
      out_word <= conv_word;
    end
  end

  // port enable and bit counter; independent of core power state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_armed <= 1'b0;
      bit_cnt    <= BIT_CNT_RST;
    end else if (cs_rise) begin
      port_armed <= 1'b1;
      bit_cnt    <= BIT_CNT_RST;
    end else if (port_armed && sck_rise && (bit_cnt != BIT_CNT_FULL)) begin
      bit_cnt <= BIT_CNT_W'(bit_cnt + 1'b1);
    end else if (port_armed && sck_fall && (bit_cnt == BIT_CNT_FULL)) begin
      port_armed <= 1'b0;
    end
  end

  // serial data pin; a rising start edge also cuts off a read left hanging
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_data_out <= 1'b0;
      serial_data_oe  <= 1'b0;
    end else if (cs_rise) begin
      serial_data_out <= 1'b0;
      serial_data_oe  <= 1'b0;
    end else if (port_armed && sck_rise && (bit_cnt != BIT_CNT_FULL)) begin
      serial_data_out <= pick_bit(out_word, bit_cnt);
      serial_data_oe  <= 1'b1;
    end else if (port_armed && sck_fall && (bit_cnt == BIT_CNT_FULL)) begin
      serial_data_out <= 1'b0;
      serial_data_oe  <= 1'b0;
    end
  end

  // status flops: power, hold, read in progress, deferred load
  // power and hold come from next-cycle values and line up with the state; read and deferral flags register current values, one cycle late
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_powered    <= 1'b0;
      core_hold       <= 1'b0;
      read_active     <= 1'b0;
      result_deferred <= 1'b0;
    end else begin
      core_powered    <= (next_state != ST_OFF);
      core_hold       <= (next_state == ST_CONV);
      read_active     <= reading;
      result_deferred <= result_pend && reading;
    end
  end

  // visible copy of the word the port is shifting
  // one cycle behind the shift word; costs a register but keeps the output a flop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_word <= RESULT_RST;
    end else begin
      result_word <= out_word;
    end
  end

endmodule : acr_adc_ctrl

// ==== src/acr_pkg.sv ====
// constants and types for the converter control and serial readout block
package acr_pkg;

  // system clock period
  localparam int CLK_PERIOD_NS = 20;

  // core power-up interval, least time
  localparam int PWRUP_TIME_NS = 1500;

  // successive-approximation conversion interval
  localparam int CONV_TIME_NS = 2300;

  // derived cycle counts, rounded up to whole cycles
  localparam int PWRUP_CYCLES = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYCLES  = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // interval timer width and terminal values
  localparam int TMR_W = 7;
  localparam logic [TMR_W-1:0] PWRUP_LAST = TMR_W'(PWRUP_CYCLES - 1);
  localparam logic [TMR_W-1:0] CONV_LAST  = TMR_W'(CONV_CYCLES - 1);
  localparam logic [TMR_W-1:0] TMR_RST    = 7'h00;

  // result word layout
  localparam int RESULT_BITS = 10;
  localparam logic [RESULT_BITS-1:0] RESULT_RST = 10'h000;

  // serial bit counter
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST  = 4'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_FULL = 4'hA;
  localparam logic [BIT_CNT_W-1:0] MSB_IDX      = 4'h9;

  // pin synchroniser reset levels; the start pin is low at power-on
  localparam logic CS_RST  = 1'b0;
  localparam logic SCK_RST = 1'b0;

  // core power states, one-hot
  typedef enum logic [3:0] {
    ST_OFF   = 4'h1,
    ST_PWRUP = 4'h2,
    ST_READY = 4'h4,
    ST_CONV  = 4'h8
  } acr_state_t;

endpackage : acr_pkg

// ==== tb/acr_adc_ctrl_asserts.sv ====
// concurrent checks on the converter control ports
`timescale 1ns/1ns
module acr_adc_ctrl_asserts
  import acr_pkg::*;
(
  input wire logic                   sys_clk,
  input wire logic                   arst_n,
  input wire logic                   conv_start_n,
  input wire logic                   shift_clock,
  input wire logic [RESULT_BITS-1:0] analog_code,
  input wire logic                   serial_data_out,
  input wire logic                   serial_data_oe,
  input wire logic                   core_powered,
  input wire logic                   core_hold,
  input wire logic                   read_active,
  input wire logic                   result_deferred,
  input wire logic [RESULT_BITS-1:0] result_word
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [6:0] hold_cnt;
  logic [6:0] pw_cnt;
  logic       cs_q;
  logic       armed;
  // interval counters; power count saturates since mode 1 stays powered
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt <= 7'h00;
      pw_cnt   <= 7'h00;
      cs_q     <= 1'b0;
      armed    <= 1'b0;
    end else begin
      hold_cnt <= core_hold ? hold_cnt + 7'h01 : 7'h00;
      pw_cnt   <= !core_powered ? 7'h00 : (pw_cnt == 7'h7F ? pw_cnt : pw_cnt + 7'h01);
      cs_q     <= conv_start_n;
      armed    <= armed | (conv_start_n & ~cs_q);
    end
  end
  AST_HOLD_LEN: assert property ($fell(core_hold) |-> hold_cnt == CONV_CYCLES)
    else $error("conversion length wrong");
  AST_HOLD_START: assert property ($rose(core_hold) |-> $past(core_powered) && !$past(conv_start_n, 2))
    else $error("hold began without falling start");
  AST_PWRUP_TIME: assert property ($rose(core_hold) |-> pw_cnt >= PWRUP_CYCLES - 2)
    else $error("conversion before power-up done");
  AST_PWR_RISE: assert property ($rose(core_powered) |-> $past(conv_start_n, 3))
    else $error("power-up without rising start");
  AST_AUTO_DOWN: assert property ($fell(core_powered) |-> !conv_start_n && !core_hold)
    else $error("power-down at wrong moment");
  AST_OE_RISE: assert property ($rose(serial_data_oe) |-> $past(shift_clock, 2) && armed)
    else $error("data driven without start edge or shift clock");
  AST_OE_FALL: assert property ($fell(serial_data_oe) |-> !$past(shift_clock, 2))
    else $error("data released off a falling shift clock");
  AST_DATA_IDLE: assert property (!serial_data_oe |-> !serial_data_out)
    else $error("data bit set while undriven");
  AST_DEFER: assert property (result_deferred |-> read_active || $past(read_active))
    else $error("result held back with no read");
  AST_WORD_HELD: assert property (result_deferred && $past(result_deferred) |-> $stable(result_word))
    else $error("shift word changed mid-read");
endmodule : acr_adc_ctrl_asserts

bind acr_adc_ctrl acr_adc_ctrl_asserts chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .conv_start_n(conv_start_n), .shift_clock(shift_clock), .analog_code(analog_code),
  .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
  .core_powered(core_powered), .core_hold(core_hold), .read_active(read_active),
  .result_deferred(result_deferred), .result_word(result_word));

// ==== tb/acr_host_model.sv ====
// host model: serial master clocking n bits in and shifting them up
`timescale 1ns/1ns
module acr_host_model (
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic [3:0]  n_clk,
  input  wire logic        sdo,
  input  wire logic        oe,
  output logic             shift_clock = 1'b0,
  output logic             busy = 1'b0,
  output logic [11:0]      word
);
  logic [2:0] ph;
  logic [3:0] left;
  // 8 sys_clk per bit; clock idles low between frames
  // sample as the clock falls: the bit has settled, and the tenth fall has not yet
  // released the pin; a released pin reads 1 through the pull-up
  always_ff @(posedge sys_clk) begin
    if (!busy) begin
      busy <= go;
      left <= n_clk;
      ph   <= 3'h0;
      if (go) word <= 12'h000;
    end else begin
      ph <= ph + 3'h1;
      if (ph == 3'h0) shift_clock <= 1'b1;
      if (ph == 3'h4) begin
        shift_clock <= 1'b0;
        word        <= {word[10:0], oe ? sdo : 1'b1};
      end
      if (ph == 3'h7) begin
        left <= left - 4'h1;
        busy <= (left != 4'h1);
      end
    end
  end
endmodule : acr_host_model

// ==== tb/test_adc_conversion_serial_readout.sv ====
// self-checking bench for the converter control and serial readout
`timescale 1ns/1ns
module test_adc_conversion_serial_readout;
  import acr_pkg::*;
  logic             sys_clk = 1'b0;
  logic             arst_n, conv_start_n, go, sdo, oe, sck, busy, pwr, hold, dfr;
  logic [3:0]       n_clk;
  logic [9:0]       code, prev, rw;
  logic [11:0]      word;
  integer           seed = 59;
  int               n_fail = 0;
  int               n_tests = 0;
  always #10 sys_clk = ~sys_clk;
  acr_adc_ctrl dut (.sys_clk(sys_clk), .arst_n(arst_n), .conv_start_n(conv_start_n),
    .shift_clock(sck), .analog_code(code), .serial_data_out(sdo), .serial_data_oe(oe),
    .core_powered(pwr), .core_hold(hold), .read_active(), .result_deferred(dfr),
    .result_word(rw));
  acr_host_model host (.sys_clk(sys_clk), .go(go), .n_clk(n_clk), .sdo(sdo), .oe(oe),
    .shift_clock(sck), .busy(busy), .word(word));
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cycles
  // bounded wait: for the core to drop power, or for conversion and deferral to clear
  task automatic settle(input bit down);
    int k;
    for (k = 0; k < 400; k++) begin
      @(posedge sys_clk);
      #1;
      if (down ? !pwr : (!hold && !dfr)) break;
    end
    if (k == 400) begin
      n_fail++;
      finish_test();
    end
  endtask : settle
  task automatic read(input logic [3:0] n);
    int k;
    @(posedge sys_clk);
    go    <= 1'b1;
    n_clk <= n;
    @(posedge sys_clk);
    go    <= 1'b0;
    for (k = 0; k < 200; k++) begin
      @(posedge sys_clk);
      #1;
      if (!busy) break;
    end
    if (k == 200) begin
      n_fail++;
      finish_test();
    end
  endtask : read
  // main sequence: idle port, auto power-down, then back-to-back mode 1 reads
  initial begin
    arst_n       = 1'b0;
    conv_start_n = 1'b0;
    go           = 1'b0;
    n_clk        = 4'hA;
    code         = 10'h000;
    cycles(8);
    arst_n <= 1'b1;
    read(4'hC);
    check(word, 12'hFFF);
    $display("idle port test done");
    prev = 10'($random(seed));
    @(posedge sys_clk);
    code         <= prev;
    conv_start_n <= 1'b1;
    cycles(10);
    conv_start_n <= 1'b0;
    settle(1'b1);
    check({11'h000, pwr}, 12'h000);
    // read while the core sleeps; the port stays armed from the earlier rise
    read(4'hA);
    check(word, {2'h0, prev});
    check({2'h0, rw}, {2'h0, prev});
    check({11'h000, pwr}, 12'h000);
    @(posedge sys_clk);
    conv_start_n <= 1'b1;
    $display("auto power-down test done");
    for (int i = 0; i < 6; i++) begin
      cycles(100);
      code         <= (i == 2) ? 10'h3FF : 10'($random(seed));
      conv_start_n <= 1'b0;
      cycles(5);
      conv_start_n <= 1'b1;
      if (i[0]) cycles(60);
      read(i[1] ? 4'hC : 4'hA);
      // reads inside the conversion get the earlier word; extra clocks find the pin released
      check(word, i[1] ? {prev, 2'h3} : {2'h0, prev});
      settle(1'b0);
      check({11'h000, pwr}, 12'h001);
      prev = code;
      $display("mode 1 read %0d done", i);
    end
    finish_test();
  end
endmodule : test_adc_conversion_serial_readout
